// [hw/fbr_burst.sv]
// Synchronous burst read sequencer of the flash device: configuration,
// address latch, first-access delay, WAIT, data hold and linear wrap.
// Assumes the link clock and strobes arrive asynchronously on pins and
// the array answers word reads on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fbr_map.svh"

module fbr_burst
  import fbr_pkg::*;
#(
  parameter int AW    = `FBR_ADDR_W,
  parameter int DEPTH = `FBR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  // Configuration port
  input  wire logic                   cfg_wr,
  input  wire fbr_pkg::fbr_rcr_t      cfg_wdata,
  output fbr_pkg::fbr_rcr_t           cfg_rdata_q,
  // Flash pins
  input  wire logic                   flash_clk,
  input  wire logic                   address_valid_strobe_n,
  input  wire logic                   chip_sel_n,
  input  wire logic                   out_en_n,
  input  wire logic [AW-1:0]          addr_pin,
  output logic [`FBR_WORD_W-1:0]      data_out_q,
  output logic                        data_oe_q,
  output logic                        wait_q,
  // Array read port
  output logic                        arr_req_q,
  output logic [AW-1:0]               arr_addr_q,
  input  wire fbr_pkg::fbr_rsp_t      arr_rsp,
  // Status
  output logic                        burst_active_q
);
  import fbr_pkg::*;

  fbr_rcr_t               rcr_q;
  fbr_pins_t              pin_s1_q;
  fbr_pins_t              pin_s2_q;
  fbr_pins_t              pin_prev_q;
  logic [AW-1:0]          addr_s1_q;
  logic [AW-1:0]          addr_s2_q;
  fbr_state_t             state_q;
  fbr_state_t             state_d;
  logic [3:0]             lat_q;
  logic [3:0]             lat_d;
  logic                   hold_q;
  logic                   hold_d;
  logic                   wait_act_q;
  logic                   wait_act_d;
  logic [AW-1:0]          base_q;
  logic [3:0]             fetch_off_q;
  logic                   pend_q;
  logic                   drop_q;
  logic                   valid_edge;
  logic                   adv_rise;
  logic                   start;
  logic                   abort;
  logic                   flush;
  logic [3:0]             grp_mask;
  logic                   issue;
  logic                   push;
  logic                   pop;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [`FBR_WORD_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcr_q <= fbr_rcr_t'(`FBR_RCR_RESET);
    end else if (clk_en && cfg_wr) begin
      rcr_q <= cfg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q <= fbr_rcr_t'(`FBR_RCR_RESET);
    end else if (clk_en) begin
      cfg_rdata_q <= rcr_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q   <= '1;
      pin_s2_q   <= '1;
      pin_prev_q <= '1;
      addr_s1_q  <= '0;
      addr_s2_q  <= '0;
    end else if (clk_en) begin
      pin_s1_q   <= '{clk: flash_clk, adv_n: address_valid_strobe_n,
                      cs_n: chip_sel_n, oe_n: out_en_n};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      addr_s1_q  <= addr_pin;
      addr_s2_q  <= addr_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and burst start
  // ----------------------------------------------------------------
  assign valid_edge = rcr_q.clock_edge_select ?
                      (pin_s2_q.clk & ~pin_prev_q.clk) :
                      (~pin_s2_q.clk & pin_prev_q.clk);
  assign adv_rise   = pin_s2_q.adv_n & ~pin_prev_q.adv_n;
  assign start      = (state_q == FBR_IDLE) && !pin_s2_q.cs_n &&
                      !rcr_q.read_style_select &&
                      (adv_rise || (valid_edge && !pin_s2_q.adv_n));
  assign abort      = (state_q != FBR_IDLE) && pin_s2_q.cs_n;
  assign flush      = start | abort;
  assign grp_mask   = (rcr_q.burst_size_code == `FBR_BL_16) ?
                      `FBR_MASK_16 : `FBR_MASK_8;

  // ----------------------------------------------------------------
  // Burst sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    lat_d      = lat_q;
    hold_d     = hold_q;
    wait_act_d = wait_act_q;
    pop        = 1'b0;
    case (state_q)
      FBR_IDLE: begin
        wait_act_d = 1'b0;
        if (start) begin
          state_d    = FBR_LAT;
          lat_d      = rcr_q.first_access_delay_code;
          hold_d     = 1'b0;
          wait_act_d = 1'b1;
        end
      end
      FBR_LAT: begin
        if (valid_edge) begin
          if (lat_q != `FBR_LAT_ZERO) begin
            lat_d = lat_q - `FBR_LAT_ONE;
            if (lat_q == `FBR_LAT_ONE && rcr_q.wait_early_select) begin
              wait_act_d = 1'b0;
            end
          end else if (fifo_out_valid) begin
            pop        = 1'b1;
            state_d    = FBR_DATA;
            hold_d     = rcr_q.output_hold_select;
            wait_act_d = 1'b0;
          end else begin
            wait_act_d = 1'b1;
          end
        end
      end
      FBR_DATA: begin
        if (valid_edge) begin
          if (hold_q) begin
            hold_d = 1'b0;
          end else if (fifo_out_valid) begin
            pop        = 1'b1;
            hold_d     = rcr_q.output_hold_select;
            wait_act_d = 1'b0;
          end else begin
            wait_act_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = FBR_IDLE;
      end
    endcase
    if (abort) begin
      state_d    = FBR_IDLE;
      wait_act_d = 1'b0;
      pop        = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= FBR_IDLE;
      lat_q      <= `FBR_LAT_ZERO;
      hold_q     <= 1'b0;
      wait_act_q <= 1'b0;
    end else if (clk_en) begin
      state_q    <= state_d;
      lat_q      <= lat_d;
      hold_q     <= hold_d;
      wait_act_q <= wait_act_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_q <= '0;
    end else if (clk_en && pop) begin
      data_out_q <= fifo_out_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_q <= 1'b0;
    end else if (clk_en) begin
      data_oe_q <= (state_d == FBR_DATA) && !pin_s2_q.oe_n;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b0;
    end else if (clk_en) begin
      wait_q <= wait_act_d ? rcr_q.wait_polarity : ~rcr_q.wait_polarity;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_active_q <= 1'b0;
    end else if (clk_en) begin
      burst_active_q <= (state_d != FBR_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Array fetch, linear wrap in aligned group
  // ----------------------------------------------------------------
  assign issue = (state_q != FBR_IDLE) && !flush && !pend_q && fifo_in_ready;
  assign push  = arr_rsp.valid && !drop_q && (state_q != FBR_IDLE) && !flush;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q      <= '0;
      fetch_off_q <= '0;
    end else if (clk_en) begin
      if (start) begin
        base_q      <= addr_s2_q;
        fetch_off_q <= addr_s2_q[`FBR_GRP_W-1:0];
      end else if (issue) begin
        fetch_off_q <= (fetch_off_q + 4'h1) & grp_mask;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_req_q  <= 1'b0;
      arr_addr_q <= '0;
    end else if (clk_en) begin
      arr_req_q <= issue;
      if (issue) begin
        arr_addr_q <= {base_q[AW-1:`FBR_GRP_W],
                       (base_q[`FBR_GRP_W-1:0] & ~grp_mask) |
                       (fetch_off_q & grp_mask)};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (clk_en) begin
      if (issue) begin
        pend_q <= 1'b1;
      end else if (arr_rsp.valid) begin
        pend_q <= 1'b0;
      end
      if (flush) begin
        drop_q <= pend_q & ~arr_rsp.valid;
      end else if (arr_rsp.valid) begin
        drop_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------
  fbr_fifo #(
    .W     (`FBR_WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .en        (clk_en),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (arr_rsp.data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

endmodule

`default_nettype wire

// [hw/fbr_fifo.sv]
// Word buffer between array fetch and the burst output.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none

module fbr_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (en && push) begin
      mem[wr_q] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and count
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (en) begin
      if (flush) begin
        wr_q  <= '0;
        rd_q  <= '0;
        cnt_q <= '0;
      end else begin
        if (push) begin
          wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [hw/fbr_map.svh]
// Named constants of the burst read sequencer: reset values, codes, sizes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FBR_MAP_SVH
`define FBR_MAP_SVH

// ----------------------------------------------------------------
// Read configuration
// ----------------------------------------------------------------
`define FBR_RCR_RESET    16'hffff
`define FBR_RCR_W        16

// ----------------------------------------------------------------
// Burst size codes and group masks
// ----------------------------------------------------------------
`define FBR_BL_8         3'h2
`define FBR_BL_16        3'h3
`define FBR_MASK_8       4'h7
`define FBR_MASK_16      4'hf
`define FBR_GRP_W        4

// ----------------------------------------------------------------
// Latency counter values
// ----------------------------------------------------------------
`define FBR_LAT_ZERO     4'h0
`define FBR_LAT_ONE      4'h1

// ----------------------------------------------------------------
// Data path
// ----------------------------------------------------------------
`define FBR_WORD_W       16
`define FBR_FIFO_DEPTH   32
`define FBR_ADDR_W       24

`endif

// [hw/fbr_pkg.sv]
// Types shared by the burst read sequencer, its checker and its testbench.
// Assumes fbr_map.svh is on the include path.
`include "fbr_map.svh"

package fbr_pkg;

  // ----------------------------------------------------------------
  // Read configuration layout, bit 15 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       read_style_select;
    logic [3:0] first_access_delay_code;
    logic       wait_polarity;
    logic       output_hold_select;
    logic       wait_early_select;
    logic       burst_order_select;
    logic       clock_edge_select;
    logic [2:0] reserved;
    logic [2:0] burst_size_code;
  } fbr_rcr_t;

  // ----------------------------------------------------------------
  // Control pins as sampled
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk;
    logic adv_n;
    logic cs_n;
    logic oe_n;
  } fbr_pins_t;

  // ----------------------------------------------------------------
  // Array read answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   valid;
    logic [`FBR_WORD_W-1:0] data;
  } fbr_rsp_t;

  typedef enum logic [1:0] {
    FBR_IDLE,
    FBR_LAT,
    FBR_DATA
  } fbr_state_t;

endpackage

// [test/fbr_burst_properties.sv]
// Checker of the burst read sequencer, bound to its top module.
// Assumes a steady link clock within frames and clk_en high.
`timescale 1ns/1ps
`default_nettype none

module fbr_burst_properties
  import fbr_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              clk_en,
  // Configuration
  input wire logic              cfg_wr,
  input wire fbr_pkg::fbr_rcr_t cfg_wdata,
  input wire fbr_pkg::fbr_rcr_t cfg_rdata_q,
  // Link
  input wire logic              chip_sel_n,
  input wire logic [15:0]       data_out_q,
  input wire logic              data_oe_q,
  input wire logic              wait_q,
  input wire logic              burst_active_q
);
  import fbr_pkg::*;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic        pol;
  logic [15:0] prev_q;
  logic [7:0]  gap_q;
  assign pol = cfg_rdata_q.wait_polarity;

  // Cycles since the last word change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 16'h0000;
      gap_q  <= 8'h00;
    end else begin
      prev_q <= data_out_q;
      gap_q  <= (data_out_q != prev_q) ? 8'h00 : gap_q + 8'h01;
    end
  end

  sequence s_start;
    $rose(burst_active_q);
  endsequence
  sequence s_wait_drop;
    burst_active_q && $changed(wait_q) && (wait_q == !pol);
  endsequence

  property p_cfg_echo;
    clk_en && cfg_wr |-> ##2 cfg_rdata_q == $past(cfg_wdata, 2);
  endproperty
  property p_page_idle;
    cfg_rdata_q.read_style_select && !burst_active_q && !$past(cfg_wr) |=> !burst_active_q;
  endproperty
  property p_idle_wait;
    !burst_active_q && !$past(burst_active_q) && !$past(cfg_wr) |-> wait_q == !pol;
  endproperty
  property p_wait_latency;
    s_start |-> (wait_q == pol) [*6];
  endproperty
  property p_wait_early;
    ((cfg_rdata_q.wait_early_select && !data_oe_q) and s_wait_drop) |-> ##[7:9] $rose(data_oe_q);
  endproperty
  property p_wait_with_data;
    ((!cfg_rdata_q.wait_early_select && !$past(data_oe_q)) and s_wait_drop) |-> data_oe_q;
  endproperty
  property p_hold;
    data_oe_q && $past(data_oe_q) && (data_out_q != prev_q)
      |-> gap_q == (cfg_rdata_q.output_hold_select ? 8'h0f : 8'h07);
  endproperty
  property p_end;
    $fell(burst_active_q) |-> chip_sel_n;
  endproperty
  property p_oe;
    data_oe_q |-> burst_active_q;
  endproperty

  a_cfg_echo:       assert property (p_cfg_echo) else $error("config readback mismatch");
  a_page_idle:      assert property (p_page_idle) else $error("burst in page mode");
  a_idle_wait:      assert property (p_idle_wait) else $error("idle wait level wrong");
  a_wait_latency:   assert property (p_wait_latency) else $error("wait not held in delay");
  a_wait_early:     assert property (p_wait_early) else $error("early wait release wrong");
  a_wait_with_data: assert property (p_wait_with_data) else $error("wait release not with data");
  a_hold:           assert property (p_hold) else $error("word hold length wrong");
  a_end:            assert property (p_end) else $error("burst ended with select low");
  a_oe:             assert property (p_oe) else $error("data driven outside burst");
endmodule

bind fbr_burst fbr_burst_properties i_fbr_burst_properties (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
  .cfg_rdata_q(cfg_rdata_q), .chip_sel_n(chip_sel_n), .data_out_q(data_out_q),
  .data_oe_q(data_oe_q), .wait_q(wait_q), .burst_active_q(burst_active_q)
);

`default_nettype wire

// [test/fbr_host_model.sv]
// Host side of the flash link: clock, strobes and address pins.
// Assumes core_clk as timing reference; link clock halts high between frames.
`timescale 1ns/1ps
`default_nettype none

module fbr_host_model (
  // Reference
  input  wire logic        core_clk,
  // Link pins
  output var  logic        flash_clk,
  output var  logic        strobe_n,
  output var  logic        cs_n,
  output var  logic        oe_n,
  output var  logic [23:0] addr
);
  initial begin
    flash_clk = 1'b1;
    strobe_n  = 1'b1;
    cs_n      = 1'b1;
    oe_n      = 1'b1;
    addr      = 24'h000000;
  end

  // ---------------------------------
  // One frame, 160 ns link period
  // ---------------------------------
  task automatic burst(input logic [23:0] a, input bit adv_low, input int toggles);
    @(posedge core_clk);
    #3;
    addr     = a;
    cs_n     = 1'b0;
    oe_n     = 1'b0;
    strobe_n = 1'b0;
    if (!adv_low) begin
      #80;
      strobe_n = 1'b1;
    end
    repeat (toggles) begin
      #80;
      flash_clk = ~flash_clk;
      if (!adv_low) addr = ~a;
    end
    #80;
    cs_n     = 1'b1;
    strobe_n = 1'b1;
    oe_n     = 1'b1;
    addr     = ~a;
  endtask
endmodule

`default_nettype wire

// [test/tb_top.sv]
// Testbench of the burst read sequencer with host model and array answer.
// Assumes the array answers one cycle after each request.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import fbr_pkg::*;

  logic        core_clk, rst_n, cfg_wr, data_oe_q, wait_q, arr_req_q, burst_active_q;
  logic        flash_clk, strobe_n, cs_n, oe_n;
  logic [23:0] addr, arr_addr_q;
  logic [15:0] data_out_q;
  logic [15:0] got[$];
  fbr_rcr_t    cfg_wdata, cfg_rdata_q;
  fbr_rsp_t    arr_rsp;
  int          failures, checks, cyc, t_act, t_oe;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  fbr_burst i_fbr_burst (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q), .flash_clk(flash_clk), .address_valid_strobe_n(strobe_n),
    .chip_sel_n(cs_n), .out_en_n(oe_n), .addr_pin(addr), .data_out_q(data_out_q),
    .data_oe_q(data_oe_q), .wait_q(wait_q), .arr_req_q(arr_req_q), .arr_addr_q(arr_addr_q),
    .arr_rsp(arr_rsp), .burst_active_q(burst_active_q));
  fbr_host_model i_fbr_host_model (
    .core_clk(core_clk), .flash_clk(flash_clk), .strobe_n(strobe_n), .cs_n(cs_n),
    .oe_n(oe_n), .addr(addr));

  // ---------------------------------
  // Array answer and word monitor
  // ---------------------------------
  always @(posedge core_clk) begin
    arr_rsp <= '{valid: arr_req_q, data: arr_addr_q[15:0] ^ 16'h5a00};
    cyc     <= cyc + 1;
    if ($rose(burst_active_q)) t_act <= cyc;
    if ($rose(data_oe_q)) t_oe <= cyc;
    if (data_oe_q === 1'b1 && (!$past(data_oe_q) || $changed(data_out_q))) got.push_back(data_out_q);
  end

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic run_burst(input logic [15:0] v, input logic [23:0] a, input bit adv_low, input int n);
    fbr_rcr_t    c;
    int          l, hf, lat;
    logic [23:0] m, w;
    c  = v;
    l  = c.first_access_delay_code;
    hf = c.output_hold_select ? 2 : 1;
    m  = (c.burst_size_code == 3'h3) ? 24'h00000f : 24'h000007;
    @(posedge core_clk);
    cfg_wr    <= 1'b1;
    cfg_wdata <= v;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk_word("cfg_readback", v, cfg_rdata_q);
    got.delete();
    i_fbr_host_model.burst(a, adv_low, 2 * (l + 2 + hf * n));
    repeat (8) @(posedge core_clk);
    lat = (c.clock_edge_select || adv_low) ? 8 * (l + 1) : 8 * l + 4;
    chk_cnt("first_word_delay", lat - 1, lat + 1, t_oe - t_act);
    chk_cnt("word_count", n, 64, got.size());
    for (int i = 0; i < n; i++) begin
      w = (a & ~m) | ((a + i) & m);
      chk_word("burst_word", w[15:0] ^ 16'h5a00, (i < got.size()) ? got[i] : 16'hxxxx);
    end
  endtask

  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task automatic t_reset_page;
    chk_word("rcr_reset", 16'hffff, cfg_rdata_q);
    chk_word("idle_wait", 16'h0000, {15'h0000, wait_q});
    got.delete();
    i_fbr_host_model.burst(24'h000010, 1'b0, 20);
    repeat (8) @(posedge core_clk);
    chk_cnt("page_mode_words", 0, 0, got.size());
  endtask

  // Code 2, rising edge, hold two, early release, wrap in 8
  task automatic t_rise_wrap8;
    run_burst(16'h17c2, 24'h000105, 1'b0, 10);
  endtask

  // Code 10, falling edge, low wait, hold one, strobe held low, wrap in 16
  task automatic t_fall_wrap16;
    run_burst(16'h5083, 24'h00123e, 1'b1, 18);
  endtask

  // Code 6, rising edge, hold one, wrap in 16
  task automatic t_rise_wrap16;
    run_burst(16'h35c3, 24'h000a07, 1'b0, 18);
  endtask

  // Code 4, falling edge, low wait, hold two, strobe held low, wrap in 8
  task automatic t_fall_wrap8;
    run_burst(16'h2282, 24'h00fffe, 1'b1, 10);
  endtask

  task automatic finish_test;
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rst_n     = 1'b0;
    cfg_wr    = 1'b0;
    cfg_wdata = 16'h0000;
    arr_rsp   = '0;
    failures  = 0;
    checks    = 0;
    cyc       = 0;
    t_act     = 0;
    t_oe      = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset_page;
    t_rise_wrap8;
    t_fall_wrap16;
    t_rise_wrap16;
    t_fall_wrap8;
    finish_test;
  end

  initial begin
    #200000;
    failures++;
    finish_test;
  end
endmodule

`default_nettype wire
